// ===== cmp_regs.svh
// Constants for the chirp modem parameter block
// Assumes inclusion by the package file, by cmp_top and by the testbench
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH
`define CMP_SF_MIN 4'h5
`define CMP_SF_MAX 4'hC
`define CMP_SF_RESET 4'h7
`define CMP_BW_NUM 2'h3
`define CMP_BW_RESET 2'h0
`define CMP_CR_MIN 3'h1
`define CMP_CR_MAX 3'h4
`define CMP_CR_RESET 3'h1
`define CMP_FMT_CHIRP 2'h1
`define CMP_FMT_RANGING 2'h2
`define CMP_CLK_HZ 40000000
`define CMP_AFC_STEP 16'h0001
`define CMP_AFC_SHIFT 3
`define CMP_MEM_WORDS 256
`endif

// ===== cmp_pkg.sv
// Types for the chirp modem parameter block
// Assumes cmp_regs.svh lies in the include path
`include "cmp_regs.svh"
package cmp_pkg;
   typedef logic [3:0] cmp_sf_t;
   typedef logic [1:0] cmp_bw_t;
   typedef logic [2:0] cmp_cr_t;
   typedef logic [1:0] cmp_fmt_t;
   typedef enum logic [2:0] {
      CMP_IDLE = 3'h1,
      CMP_FMT_SET = 3'h2,
      CMP_ACTIVE = 3'h4
   } cmp_state_e;
endpackage

// ===== cmp_mem.sv
// Packet memory shared by all modems
// Assumes one writer and one reader per cycle, chosen by the top
`timescale 1ns/10ps
module cmp_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== cmp_top.sv
// Chirp modem parameter and rate logic with shared packet memory
// Assumes host commands arrive as one-cycle strobes synchronous to CLK
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_top
   import cmp_pkg::*;
#(
   parameter int MEM_WIDTH = 8,
   parameter int MEM_AW = 8
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic SELECT_FRAME_FORMAT_CMD,
   input wire cmp_pkg::cmp_fmt_t FRAME_FORMAT,
   input wire logic WRITE_MODULATION_SETTINGS_CMD,
   input wire cmp_pkg::cmp_sf_t CHIP_RATIO_EXPONENT,
   input wire cmp_pkg::cmp_bw_t CHIRP_BANDWIDTH,
   input wire cmp_pkg::cmp_cr_t FEC_REDUNDANCY_SETTING,
   input wire logic signed [15:0] FREQ_ERROR,
   input wire logic MEM_WR_EN,
   input wire logic [MEM_AW-1:0] MEM_WR_ADDR,
   input wire logic [MEM_WIDTH-1:0] MEM_WR_DATA,
   input wire logic [MEM_AW-1:0] MEM_RD_ADDR,
   output logic [MEM_WIDTH-1:0] MEM_RD_DATA,
   output logic SETTINGS_VALID,
   output logic SETTINGS_REJECTED,
   output logic RANGING_MODE,
   output cmp_pkg::cmp_sf_t SF_OUT,
   output cmp_pkg::cmp_cr_t HEADER_CODING,
   output logic [12:0] CHIPS_PER_SYMBOL,
   output logic [10:0] CHIP_RATE_KHZ,
   output logic [31:0] SYMBOL_PERIOD_NS,
   output logic [31:0] RAW_RATE_BPS,
   output logic [31:0] EFF_RATE_BPS,
   output logic signed [15:0] FREQ_CORRECTION
);
   cmp_state_e state_reg, state_next;
   cmp_sf_t sf_reg;
   cmp_bw_t bw_reg;
   cmp_cr_t cr_reg;
   cmp_fmt_t fmt_reg;
   logic signed [15:0] afc_reg;

   // ------------------------------------------------------------
   // Command sequencing
   // ------------------------------------------------------------
   // settings taken only after format
   wire fmt_ok = SELECT_FRAME_FORMAT_CMD &&
      (FRAME_FORMAT == `CMP_FMT_CHIRP || FRAME_FORMAT == `CMP_FMT_RANGING);
   wire sf_ok = CHIP_RATIO_EXPONENT >= `CMP_SF_MIN && CHIP_RATIO_EXPONENT <= `CMP_SF_MAX;
   wire cr_ok = FEC_REDUNDANCY_SETTING >= `CMP_CR_MIN && FEC_REDUNDANCY_SETTING <= `CMP_CR_MAX;
   wire cmd_ok = WRITE_MODULATION_SETTINGS_CMD && sf_ok && cr_ok && state_reg != CMP_IDLE;
   wire cmd_bad = WRITE_MODULATION_SETTINGS_CMD && !cmd_ok;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         CMP_IDLE: begin
            if (fmt_ok) begin
               state_next = CMP_FMT_SET;
            end
         end
         CMP_FMT_SET: begin
            if (cmd_ok) begin
               state_next = CMP_ACTIVE;
            end
         end
         CMP_ACTIVE: begin
            if (fmt_ok) begin
               state_next = CMP_FMT_SET;
            end
         end
         default: begin
            state_next = CMP_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_reg <= CMP_IDLE;
         fmt_reg <= `CMP_FMT_CHIRP;
      end else begin
         state_reg <= state_next;
         if (fmt_ok) begin
            fmt_reg <= FRAME_FORMAT;
         end
      end
   end

   // ------------------------------------------------------------
   // Held modulation settings
   // ------------------------------------------------------------
   // hold until next accepted write
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sf_reg <= `CMP_SF_RESET;
         bw_reg <= `CMP_BW_RESET;
         cr_reg <= `CMP_CR_RESET;
      end else if (cmd_ok) begin
         sf_reg <= CHIP_RATIO_EXPONENT;
         bw_reg <= CHIRP_BANDWIDTH;
         cr_reg <= FEC_REDUNDANCY_SETTING;
      end
   end

   // ------------------------------------------------------------
   // Rate derivation
   // ------------------------------------------------------------
   // chips per symbol
   wire [12:0] chips = 13'h0001 << sf_reg;
   wire [10:0] bw_khz = (bw_reg == 2'h0) ? 11'd203 : (bw_reg == 2'h1) ? 11'd406 :
      (bw_reg == 2'h2) ? 11'd812 : 11'd1625;
   // symbol period from chips and bandwidth
   wire [31:0] ts_ns = (32'(chips) * 32'd1000000) / 32'(bw_khz);
   // raw rate from exponent, bandwidth and chips per symbol
   wire [31:0] rb_bps = (32'(sf_reg) * 32'(bw_khz) * 32'd1000) / 32'(chips);
   wire [31:0] rbeff_bps = (rb_bps * 32'd4) / (32'd4 + 32'(cr_reg));

   // ------------------------------------------------------------
   // Automatic frequency correction
   // ------------------------------------------------------------
   // tracks error with no host control
   wire signed [15:0] afc_step = FREQ_ERROR >>> `CMP_AFC_SHIFT;
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         afc_reg <= 16'sh0000;
      end else begin
         afc_reg <= afc_reg - afc_step;
      end
   end

   // ------------------------------------------------------------
   // Shared packet memory
   // ------------------------------------------------------------
   // one memory for every modem
   cmp_mem #(.WIDTH(MEM_WIDTH), .DEPTH(`CMP_MEM_WORDS), .AW(MEM_AW)) u_mem (
      .clk(CLK),
      .wr_en(MEM_WR_EN),
      .wr_addr(MEM_WR_ADDR),
      .wr_data(MEM_WR_DATA),
      .rd_addr(MEM_RD_ADDR),
      .rd_data(MEM_RD_DATA)
   );

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SETTINGS_VALID <= 1'b0;
         SETTINGS_REJECTED <= 1'b0;
         RANGING_MODE <= 1'b0;
         SF_OUT <= `CMP_SF_RESET;
         HEADER_CODING <= `CMP_CR_RESET;
         CHIPS_PER_SYMBOL <= 13'h0000;
         CHIP_RATE_KHZ <= 11'h000;
         SYMBOL_PERIOD_NS <= 32'h0;
         RAW_RATE_BPS <= 32'h0;
         EFF_RATE_BPS <= 32'h0;
         FREQ_CORRECTION <= 16'sh0000;
      end else begin
         SETTINGS_VALID <= state_reg == CMP_ACTIVE;
         SETTINGS_REJECTED <= cmd_bad;
         RANGING_MODE <= fmt_reg == `CMP_FMT_RANGING;
         SF_OUT <= sf_reg;
         HEADER_CODING <= cr_reg;
         CHIPS_PER_SYMBOL <= chips;
         CHIP_RATE_KHZ <= bw_khz;
         SYMBOL_PERIOD_NS <= ts_ns;
         RAW_RATE_BPS <= rb_bps;
         EFF_RATE_BPS <= rbeff_bps;
         FREQ_CORRECTION <= afc_reg;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_early_write;
      state_reg == CMP_IDLE && WRITE_MODULATION_SETTINGS_CMD;
   endsequence
   a_early_write_refused: assert property (@(posedge CLK) disable iff (!RESET_N)
      s_early_write |=> SETTINGS_REJECTED && $stable(sf_reg)) else $error("early write accepted");
   a_settings_held: assert property (@(posedge CLK) disable iff (!RESET_N)
      !cmd_ok |=> $stable(sf_reg) && $stable(bw_reg) && $stable(cr_reg)) else $error("settings changed");
   a_chips_power: assert property (@(posedge CLK) disable iff (!RESET_N)
      cmd_ok |-> ##2 CHIPS_PER_SYMBOL == (13'h0001 << $past(CHIP_RATIO_EXPONENT, 2))) else $error("chips wrong");
   a_sf_range: assert property (@(posedge CLK) disable iff (!RESET_N)
      sf_reg >= `CMP_SF_MIN && sf_reg <= `CMP_SF_MAX) else $error("exponent out of range");
   a_bw_range: assert property (@(posedge CLK) disable iff (!RESET_N)
      $past(RESET_N, 2) |-> CHIP_RATE_KHZ >= 11'd203 && CHIP_RATE_KHZ <= 11'd1625)
      else $error("bandwidth out of range");
   a_eff_rate: assert property (@(posedge CLK) disable iff (!RESET_N)
      EFF_RATE_BPS <= RAW_RATE_BPS) else $error("effective rate above raw");
   a_ranging_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
      fmt_ok && FRAME_FORMAT == `CMP_FMT_RANGING |-> ##2 RANGING_MODE) else $error("ranging flag missing");
   a_header_coding: assert property (@(posedge CLK) disable iff (!RESET_N)
      cmd_ok |-> ##2 HEADER_CODING == $past(FEC_REDUNDANCY_SETTING, 2)) else $error("header coding wrong");
endmodule

// ===== cmp_host.sv
// Host model issuing frame format and modulation commands
// Assumes the same clock as the parameter block; drives just after rising edges
`timescale 1ns/10ps
module cmp_host
   import cmp_pkg::*;
(
   input wire logic clk,
   output logic fmt_cmd,
   output cmp_pkg::cmp_fmt_t fmt,
   output logic mod_cmd,
   output cmp_pkg::cmp_sf_t sf,
   output cmp_pkg::cmp_bw_t bw,
   output cmp_pkg::cmp_cr_t cr
);
   initial begin
      fmt_cmd = 1'b0;
      fmt = 2'h0;
      mod_cmd = 1'b0;
      sf = 4'h0;
      bw = 2'h0;
      cr = 3'h0;
   end
   task automatic frame(input logic [1:0] f);
      @(posedge clk);
      fmt_cmd <= 1'b1;
      fmt <= f;
      @(posedge clk);
      fmt_cmd <= 1'b0;
      fmt <= ~f;
   endtask
   // exponent held for one cycle, then inverted
   // Lines idle inverted so a stale value never equals the one just sent
   task automatic modset(input logic [3:0] s, input logic [1:0] b, input logic [2:0] c);
      @(posedge clk);
      mod_cmd <= 1'b1;
      sf <= s;
      bw <= b;
      cr <= c;
      @(posedge clk);
      mod_cmd <= 1'b0;
      sf <= ~s;
      bw <= ~b;
      cr <= ~c;
   endtask
endmodule

// ===== cmp_top_tb.sv
// Self-checking bench for the chirp modem parameter block
// Assumes cmp_pkg and cmp_host compiled first; 40 MHz clock
`timescale 1ns/10ps
`include "cmp_regs.svh"
module cmp_top_tb;
   import cmp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fc, mc, we, vld, rej, rng;
   cmp_fmt_t fm;
   cmp_sf_t sf, sfo;
   cmp_bw_t bw;
   cmp_cr_t cr, hc;
   logic signed [15:0] ferr = 16'sh0000;
   logic signed [15:0] fcor;
   logic [7:0] wa = 8'h00, wd = 8'h00, ra = 8'h00, rd;
   logic [12:0] cps;
   logic [10:0] khz;
   logic [31:0] per, raw, eff;
   int fail_count = 0;
   int checks = 0;
   int c;
   logic [7:0] d;
   always #12.5 clk = ~clk;
   cmp_host i_cmp_host (.clk(clk), .fmt_cmd(fc), .fmt(fm), .mod_cmd(mc), .sf(sf), .bw(bw), .cr(cr));
   cmp_top i_cmp_top (.CLK(clk), .RESET_N(rst_n), .SELECT_FRAME_FORMAT_CMD(fc), .FRAME_FORMAT(fm),
      .WRITE_MODULATION_SETTINGS_CMD(mc), .CHIP_RATIO_EXPONENT(sf), .CHIRP_BANDWIDTH(bw),
      .FEC_REDUNDANCY_SETTING(cr), .FREQ_ERROR(ferr), .MEM_WR_EN(we), .MEM_WR_ADDR(wa), .MEM_WR_DATA(wd),
      .MEM_RD_ADDR(ra), .MEM_RD_DATA(rd), .SETTINGS_VALID(vld), .SETTINGS_REJECTED(rej), .RANGING_MODE(rng),
      .SF_OUT(sfo), .HEADER_CODING(hc), .CHIPS_PER_SYMBOL(cps), .CHIP_RATE_KHZ(khz), .SYMBOL_PERIOD_NS(per),
      .RAW_RATE_BPS(raw), .EFF_RATE_BPS(eff), .FREQ_CORRECTION(fcor));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("mismatches=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Reference model: integer rates, truncated
   task automatic chk_set(input int s, input int b, input int r);
      longint k;
      longint rb;
      k = (b == 3) ? 1625 : (203 << b);
      rb = (longint'(s) * k * 1000) >> s;
      chk(sfo, s);
      chk(hc, r);
      chk(cps, 1 << s);
      chk(khz, k);
      chk(per, (longint'(1 << s) * 1000000) / k);
      chk(raw, rb);
      chk(eff, rb * 4 / (4 + r));
   endtask
   // ---------------------------------------
   // Main sequence
   // ---------------------------------------
   initial begin
      we = 1'b0;
      void'($urandom(32'h3d4a));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk(vld, 1'b0);
      chk(fcor, 16'h0000);
      chk_set(7, 0, 1);
      i_cmp_host.modset(4'h9, 2'h1, 3'h2);
      #1;
      chk(rej, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      chk_set(7, 0, 1);
      i_cmp_host.frame(`CMP_FMT_RANGING);
      @(posedge clk);
      #1;
      chk(rng, 1'b1);
      for (int s = 5; s <= 12; s++) begin
         for (int b = 0; b < 4; b++) begin
            c = $urandom_range(4, 1);
            i_cmp_host.modset(s[3:0], b[1:0], c[2:0]);
            repeat (2) @(posedge clk);
            #1;
            chk(vld, 1'b1);
            chk_set(s, b, c);
         end
      end
      // Out-of-range exponent and coding must leave settings alone
      for (int i = 0; i < 4; i++) begin
         i_cmp_host.modset(i == 0 ? 4'h4 : i == 1 ? 4'hD : 4'h7, 2'h0, i == 2 ? 3'h0 : i == 3 ? 3'h5 : 3'h1);
         #1;
         chk(rej, 1'b1);
         repeat (2) @(posedge clk);
         #1;
         chk_set(12, 3, c);
      end
      i_cmp_host.frame(`CMP_FMT_CHIRP);
      @(posedge clk);
      #1;
      chk(rng, 1'b0);
      @(posedge clk);
      ferr <= 16'sh0080;
      repeat (10) @(posedge clk);
      #1;
      chk(fcor[15], 1'b1);
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         @(posedge clk);
         we <= 1'b1;
         wa <= d ^ 8'h5A;
         wd <= d;
         @(posedge clk);
         we <= 1'b0;
         wd <= ~d;
         ra <= d ^ 8'h5A;
         @(posedge clk);
         #1;
         chk(rd, d);
      end
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      finish_test();
   end
endmodule
